/* File: gec_regs.vh */
// Constants for the gated event counter: register offsets, field positions,
// reset values, mode and pulse-source codes. Assumes an 8-bit register port.
// Operation
// - Gate enabled: count only while gate high
// - Gate is channel 0 toggle flip-flop
// - Interrupt on both gate edges
// - Gate low: stop and hold count
// - PWM mode: 8-bit pulse generator
// - Mode register field layout
// - Whole-byte writes, bit 3 alone too
// - Start bit clears itself automatically
// - Reset clears mode register to zero
// - Start bit clears counter and flag
// - Run bit zero stops and holds
// - Gate disabled: count whenever run set
// - Match sets flag and toggles output
`ifndef GEC_REGS_VH
`define GEC_REGS_VH
`define GEC_ADDR_W        12
`define GEC_OFF_MODE2     12'hF90
`define GEC_OFF_MODE0     12'hF80
`define GEC_OFF_MATCH0    12'hF84
`define GEC_OFF_MATCH2    12'hF94
`define GEC_OFF_MATCH2H   12'hF98
`define GEC_OFF_COUNT2    12'hF9C
`define GEC_OFF_CTRL      12'hFA0
`define GEC_OFF_BIT3SET   12'hFA4
`define GEC_OFF_IRQSTAT   12'hFB0
`define GEC_OFF_IRQEN     12'hFB4
`define GEC_OFF_IRQCLR    12'hFB8
`define GEC_MODE_RST      8'h00
`define GEC_ZERO8         8'h00
`define GEC_ONE8          8'h01
`define GEC_STAT_RST      4'h0
`define GEC_SRC_HI        6
`define GEC_SRC_LO        4
`define GEC_START_BIT     3
`define GEC_RUN_BIT       2
`define GEC_MODE_HI       1
`define GEC_MODE_LO       0
`define GEC_MODE_MASK     8'h7F
`define GEC_GATE_EN_BIT   7
`define GEC_MODE_TIMER    2'h0
`define GEC_MODE_PWM      2'h1
`define GEC_SRC_TI_RISE   3'h0
`define GEC_SRC_TI_FALL   3'h1
`define GEC_SRC_DIV2      3'h2
`define GEC_SRC_DIV1      3'h3
`define GEC_SRC_DIV1K     3'h4
`define GEC_SRC_DIV256    3'h5
`define GEC_SRC_DIV64     3'h6
`define GEC_SRC_DIV16     3'h7
`define GEC_PS_W          10
`define GEC_PS_ONE        10'h001
`define GEC_IRQ_GRISE     0
`define GEC_IRQ_GFALL     1
`define GEC_IRQ_MATCH2    2
`define GEC_IRQ_MATCH0    3
`endif

/* File: gec_counter.v */
// Channel 2 gated event counter with its channel 0 gate timer and PWM mode.
// Assumes register strobes and the event pin are synchronous to sys_clk.
`timescale 1ns/10ps
`include "gec_regs.vh"
module gec_counter
(
  input  wire                   sys_clk,
  input  wire                   reset,
  input  wire [`GEC_ADDR_W-1:0] regAddr,
  input  wire [7:0]             regWdata,
  input  wire                   regWrite,
  input  wire                   regRead,
  output reg  [7:0]             regRdata_r,
  input  wire                   eventInputPin,
  output reg                    gateOut_r,
  output reg                    pwmOut_r,
  output reg                    irq_r
);

  reg [7:0]           counter2ModeSetting_r;
  reg [7:0]           counter0ModeSetting_r;
  reg [7:0]           counter0MatchValue_r;
  reg [7:0]           counter2MatchValue_r;
  reg [7:0]           highPeriodMatchValue_r;
  reg [7:0]           counterControlSetting_r;
  reg [7:0]           counter2Count_r;
  reg [7:0]           counter0Count_r;
  reg [3:0]           irqStatus_r;
  reg [3:0]           irqEnable_r;
  reg                 timerOutToggle_r;
  reg                 gateSampled_r;
  reg                 eventPrev_r;
  reg [`GEC_PS_W-1:0] prescale_r;
  reg [`GEC_PS_W-1:0] prescalePrev_r;
  reg                 start2Pend_r;
  reg                 start0Pend_r;

  wire writeMode2 = regWrite && (regAddr == `GEC_OFF_MODE2);
  wire writeBit3  = regWrite && (regAddr == `GEC_OFF_BIT3SET);
  wire writeMode0 = regWrite && (regAddr == `GEC_OFF_MODE0);
  wire start2 = (writeMode2 && regWdata[`GEC_START_BIT]) ||
                (writeBit3 && regWdata[0]);
  wire start0 = writeMode0 && regWdata[`GEC_START_BIT];

  // Select one count pulse from the source field; prescaler taps are
  // rising-edge detected so each source yields one-cycle pulses.
  function countPulse;
    input [2:0]           src;
    input                 pin;
    input                 pinPrev;
    input [`GEC_PS_W-1:0] ps;
    input [`GEC_PS_W-1:0] psPrev;
    begin
      case (src)
        `GEC_SRC_TI_RISE: countPulse = pin && !pinPrev;
        `GEC_SRC_TI_FALL: countPulse = !pin && pinPrev;
        `GEC_SRC_DIV2:    countPulse = ps[0] && !psPrev[0];
        `GEC_SRC_DIV1:    countPulse = 1'b1;
        `GEC_SRC_DIV1K:   countPulse = ps[9] && !psPrev[9];
        `GEC_SRC_DIV256:  countPulse = ps[7] && !psPrev[7];
        `GEC_SRC_DIV64:   countPulse = ps[5] && !psPrev[5];
        default:          countPulse = ps[3] && !psPrev[3];
      endcase
    end
  endfunction

  wire cp2 = countPulse(counter2ModeSetting_r[`GEC_SRC_HI:`GEC_SRC_LO],
                        eventInputPin, eventPrev_r, prescale_r,
                        prescalePrev_r);
  wire cp0 = countPulse(counter0ModeSetting_r[`GEC_SRC_HI:`GEC_SRC_LO],
                        eventInputPin, eventPrev_r, prescale_r,
                        prescalePrev_r);

  wire run2 = counter2ModeSetting_r[`GEC_RUN_BIT];
  wire run0 = counter0ModeSetting_r[`GEC_RUN_BIT];
  wire gateEn = counterControlSetting_r[`GEC_GATE_EN_BIT];
  wire pwmMode = counter2ModeSetting_r[`GEC_MODE_HI:`GEC_MODE_LO] ==
                 `GEC_MODE_PWM;
  // Gated counting uses the registered gate, so a gate edge and a pulse in
  // the same cycle always resolve the same way.
  wire gateOk = !gateEn || gateSampled_r;
  wire inc2 = run2 && cp2 && gateOk && !start2Pend_r;
  wire inc0 = run0 && cp0 && !start0Pend_r;
  wire match0 = inc0 && (counter0Count_r == counter0MatchValue_r);
  wire match2 = inc2 && (counter2Count_r == counter2MatchValue_r);
  wire matchH = inc2 && pwmMode &&
                (counter2Count_r == highPeriodMatchValue_r);
  wire gateRise = timerOutToggle_r && !gateSampled_r;
  wire gateFall = !timerOutToggle_r && gateSampled_r;

  // Free-running prescaler and input history for edge detection
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prescale_r     <= {`GEC_PS_W{1'b0}};
      prescalePrev_r <= {`GEC_PS_W{1'b0}};
      eventPrev_r    <= 1'b0;
      gateSampled_r  <= 1'b0;
    end
    else
    begin
      prescale_r     <= prescale_r + `GEC_PS_ONE;
      prescalePrev_r <= prescale_r;
      eventPrev_r    <= eventInputPin;
      gateSampled_r  <= timerOutToggle_r;
    end
  end

  // Configuration registers. Mode 2 is a whole-byte register; bit 3 has its
  // own single-bit alias. The start bit never reads back as set.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      counter2ModeSetting_r   <= `GEC_MODE_RST;
      counter0ModeSetting_r   <= `GEC_MODE_RST;
      counter0MatchValue_r    <= `GEC_ZERO8;
      counter2MatchValue_r    <= `GEC_ZERO8;
      highPeriodMatchValue_r  <= `GEC_ZERO8;
      counterControlSetting_r <= `GEC_ZERO8;
      irqEnable_r             <= `GEC_STAT_RST;
      start2Pend_r            <= 1'b0;
      start0Pend_r            <= 1'b0;
    end
    else
    begin
      // Channel 2 mode: the start bit acts at once and is never stored,
      // so a read can never return a start that is still pending.
      if (writeMode2)
      begin
        counter2ModeSetting_r <= regWdata & `GEC_MODE_MASK &
                                 ~(8'h01 << `GEC_START_BIT);
      end
      // Channel 0 mode: same layout, same self-clearing start bit
      if (writeMode0)
      begin
        counter0ModeSetting_r <= regWdata & `GEC_MODE_MASK &
                                 ~(8'h01 << `GEC_START_BIT);
      end
      // Channel 0 match value; zero is a software error, not trapped
      if (regWrite && regAddr == `GEC_OFF_MATCH0)
      begin
        counter0MatchValue_r <= regWdata;
      end
      // Channel 2 match value, the period in PWM mode
      if (regWrite && regAddr == `GEC_OFF_MATCH2)
      begin
        counter2MatchValue_r <= regWdata;
      end
      // High-period match, used only in PWM mode
      if (regWrite && regAddr == `GEC_OFF_MATCH2H)
      begin
        highPeriodMatchValue_r <= regWdata;
      end
      // Control register; only the gate enable bit is used here
      if (regWrite && regAddr == `GEC_OFF_CTRL)
      begin
        counterControlSetting_r <= regWdata;
      end
      // Interrupt enables share the status layout
      if (regWrite && regAddr == `GEC_OFF_IRQEN)
      begin
        irqEnable_r <= regWdata[3:0];
      end
      // One-cycle hold-off after a start, so the cleared counter is
      // not bumped in the same cycle that software sees it at zero.
      start2Pend_r <= start2;
      start0Pend_r <= start0;
    end
  end

  // Channel 2 counter: the start command clears it, a match wraps it.
  // A start beats a match, so software always sees a clean zero.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      counter2Count_r <= `GEC_ZERO8;
    end
    else if (start2)
    begin
      counter2Count_r <= `GEC_ZERO8;
    end
    else if (match2)
    begin
      counter2Count_r <= `GEC_ZERO8;
    end
    else if (inc2)
    begin
      // Held value when no pulse, run off or gate low
      counter2Count_r <= counter2Count_r + `GEC_ONE8;
    end
  end

  // Channel 0 timer: its toggle flip-flop is the gate of channel 2.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      counter0Count_r  <= `GEC_ZERO8;
      timerOutToggle_r <= 1'b0;
    end
    else if (start0)
    begin
      counter0Count_r  <= `GEC_ZERO8;
      timerOutToggle_r <= 1'b0;
    end
    else if (match0)
    begin
      counter0Count_r  <= `GEC_ZERO8;
      timerOutToggle_r <= !timerOutToggle_r;
    end
    else if (inc0)
      counter0Count_r <= counter0Count_r + `GEC_ONE8;
  end

  // PWM output toggles on both the high-period match and the period match
  // Equal match values would toggle twice in one cycle; the XOR keeps
  // the level unchanged then, which is the net effect of two toggles.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      pwmOut_r <= 1'b0;
    end
    else if (start2)
    begin
      pwmOut_r <= 1'b0;
    end
    else if (matchH ^ match2)
    begin
      pwmOut_r <= !pwmOut_r;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      irqStatus_r <= `GEC_STAT_RST;
    else
    begin
      irqStatus_r <= (irqStatus_r &
                      ~((regWrite && regAddr == `GEC_OFF_IRQCLR) ?
                        regWdata[3:0] : `GEC_STAT_RST) &
                      ~{1'b0, start2, 2'b00}) |
                     {match0, match2, gateFall, gateRise};
    end
  end

  // Registered outputs
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_r     <= 1'b0;
      gateOut_r <= 1'b0;
    end
    else
    begin
      irq_r     <= |(irqStatus_r & irqEnable_r);
      gateOut_r <= timerOutToggle_r;
    end
  end

  // Read port; unmapped and write-only offsets read as zero.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      regRdata_r <= `GEC_ZERO8;
    else if (regRead)
    begin
      case (regAddr)
        `GEC_OFF_MODE2:   regRdata_r <= counter2ModeSetting_r;
        `GEC_OFF_MODE0:   regRdata_r <= counter0ModeSetting_r;
        `GEC_OFF_MATCH0:  regRdata_r <= counter0MatchValue_r;
        `GEC_OFF_MATCH2:  regRdata_r <= counter2MatchValue_r;
        `GEC_OFF_MATCH2H: regRdata_r <= highPeriodMatchValue_r;
        `GEC_OFF_COUNT2:  regRdata_r <= counter2Count_r;
        `GEC_OFF_CTRL:    regRdata_r <= counterControlSetting_r;
        `GEC_OFF_IRQSTAT: regRdata_r <= {4'h0, irqStatus_r};
        `GEC_OFF_IRQEN:   regRdata_r <= {4'h0, irqEnable_r};
        default:          regRdata_r <= `GEC_ZERO8;
      endcase
    end
    else
      regRdata_r <= `GEC_ZERO8;
  end

endmodule

/* File: gec_chk.sv */
// Port checker for the gated event counter.
// Assumes binding to gec_counter; sees only its ports.
`timescale 1ns/10ps
`include "gec_regs.vh"
module gec_chk
(
  input logic                   sys_clk,
  input logic                   reset,
  input logic [`GEC_ADDR_W-1:0] regAddr,
  input logic [7:0]             regWdata,
  input logic                   regWrite,
  input logic                   regRead,
  input logic [7:0]             regRdata_r,
  input logic                   eventInputPin,
  input logic                   gateOut_r,
  input logic                   pwmOut_r,
  input logic                   irq_r
);
  logic [7:0] modeR_r;
  logic [3:0] enR_r;
  logic       ch0On_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Shadows of software writes; the mode 2 shadow never keeps the start bit, ch0On_r records a channel 0 start
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      modeR_r <= 8'h00;
      enR_r   <= 4'h0;
      ch0On_r <= 1'b0;
    end
    else if (regWrite)
    begin
      if (regAddr == `GEC_OFF_MODE2) modeR_r <= regWdata & 8'h77;
      if (regAddr == `GEC_OFF_IRQEN) enR_r <= regWdata[3:0];
      if (regAddr == `GEC_OFF_MODE0 && regWdata[3]) ch0On_r <= 1'b1;
    end
  sequence s_mode_read;
    $past(regRead) && $past(regAddr) == `GEC_OFF_MODE2;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    reset |-> regRdata_r == 8'h00 && !irq_r && !gateOut_r)
    else $error("outputs not clear in reset");
  a_mode_readback: assert property (s_mode_read |->
    regRdata_r == modeR_r) else $error("mode readback wrong");
  a_rdata_idle: assert property (!$past(regRead) |->
    regRdata_r == 8'h00) else $error("read data outside slot");
  a_gate_rise: assert property ($rose(gateOut_r) && enR_r[0]
    |-> ##[1:3] irq_r) else $error("no irq on gate rise");
  a_gate_fall: assert property ($fell(gateOut_r) && enR_r[1]
    |-> ##[1:3] irq_r) else $error("no irq on gate fall");
  a_irq_masked: assert property ($past(enR_r) == 4'h0
    |-> !irq_r) else $error("irq while masked");
  a_gate_hold: assert property ($changed(gateOut_r)
    |=> $stable(gateOut_r)) else $error("gate toggled twice");
  a_gate_idle: assert property (!ch0On_r |-> !gateOut_r)
    else $error("gate moved before start");
endmodule
bind gec_counter gec_chk chk_u (.sys_clk, .reset, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata_r, .eventInputPin, .gateOut_r,
  .pwmOut_r, .irq_r);

/* File: gec_pin_model.sv */
// Event pin model: sends a burst of one-cycle-high pulses on request.
// Assumes sys_clk timing; the pin rests low between bursts.
`timescale 1ns/10ps
module gec_pin_model
(
  input  logic       sys_clk,
  input  logic       reset,
  input  logic [7:0] pulseNum,
  input  logic       pulseGo,
  output logic       eventInputPin,
  output logic       pulseBusy
);
  logic [7:0] left_r;
  // High then low, so each pulse shows both edges
  always_ff @(posedge sys_clk or posedge reset)
    if (reset)
    begin
      left_r        <= 8'h00;
      eventInputPin <= 1'b0;
    end
    else if (pulseGo)
      left_r <= pulseNum;
    else if (left_r != 8'h00)
    begin
      eventInputPin <= ~eventInputPin;
      if (eventInputPin) left_r <= left_r - 8'h01;
    end
  assign pulseBusy = (left_r != 8'h00);
endmodule

/* File: gated_event_counter_pwm_setup_test.sv */
// Directed bench for the gated event counter over its register port.
// Assumes the pin model on the event input and the bound checker.
`timescale 1ns/10ps
`include "gec_regs.vh"
module gated_event_counter_pwm_setup_test;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0]  regWdata = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  pulseNum = 8'h00;
  logic        pulseGo = 1'b0;
  logic [7:0]  d;
  wire  [7:0]  regRdata_r;
  wire         eventInputPin, gateOut_r, pwmOut_r, irq_r, pulseBusy;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n, a;
  always #2 sys_clk = ~sys_clk;
  gec_counter dut_u (.sys_clk, .reset, .regAddr, .regWdata, .regWrite,
    .regRead, .regRdata_r, .eventInputPin, .gateOut_r, .pwmOut_r, .irq_r);
  gec_pin_model pin_u (.sys_clk, .reset, .pulseNum, .pulseGo,
    .eventInputPin, .pulseBusy);
  task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_compared++;
    if (got !== ex)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Strobes rise and fall on separate edges, so calls never collide
  task wr(input logic [11:0] ad, input logic [7:0] dt);
    @(posedge sys_clk);
    regAddr <= ad;
    regWdata <= dt;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task rc(input logic [11:0] ad, input logic [7:0] ex, input string nm);
    @(posedge sys_clk);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdata_r;
    chk(nm, ex, d);
  endtask
  // Cycles until the chosen output changes; bounded against a hang
  task wait_chg(input bit pwm, output int cnt);
    logic v;
    #1 v = pwm ? pwmOut_r : gateOut_r;
    cnt = 0;
    while ((pwm ? pwmOut_r : gateOut_r) === v && cnt < 500)
    begin
      @(posedge sys_clk);
      #1 cnt++;
    end
  endtask
  task pulses(input logic [7:0] k);
    @(posedge sys_clk);
    pulseNum <= k;
    pulseGo <= 1'b1;
    @(posedge sys_clk);
    pulseGo <= 1'b0;
    #1;
    for (n = 0; n < 600 && pulseBusy !== 1'b0; n++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask
  task print_verdict;
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #40000;
    bad_count++;
    print_verdict;
  end
  initial
  begin
    // Raised from low so the asynchronous reset sees a real edge
    reset <= 1'b1;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    rc(`GEC_OFF_MODE2, 8'h00, "mode2 reset");
    rc(12'h000, 8'h00, "unmapped");
    // Every source code; bit 7 and the start bit read back as 0
    for (a = 0; a < 8; a++)
    begin
      wr(`GEC_OFF_MODE2, {1'b1, a[2:0], 4'h8});
      rc(`GEC_OFF_MODE2, {1'b0, a[2:0], 4'h0}, "mode2");
    end
    // Ungated counting of pin rising edges, then stop and clear
    wr(`GEC_OFF_MATCH2, 8'hFF);
    wr(`GEC_OFF_MODE2, 8'h0C);
    pulses(8'h05);
    rc(`GEC_OFF_COUNT2, 8'h05, "ungated");
    wr(`GEC_OFF_MODE2, 8'h00);
    pulses(8'h05);
    rc(`GEC_OFF_COUNT2, 8'h05, "stopped");
    wr(`GEC_OFF_BIT3SET, 8'h01);
    rc(`GEC_OFF_COUNT2, 8'h00, "cleared");
    // Gated counting; channel 0 holds each gate phase 20 cycles
    wr(`GEC_OFF_IRQEN, 8'h03);
    wr(`GEC_OFF_CTRL, 8'h80);
    wr(`GEC_OFF_MODE2, 8'h3C);
    wr(`GEC_OFF_MATCH0, 8'h13);
    wr(`GEC_OFF_MODE0, 8'h3C);
    wait_chg(1'b0, n);
    wait_chg(1'b0, n);
    chk("gate span", 8'h14, n[7:0]);
    repeat (2) @(posedge sys_clk);
    rc(`GEC_OFF_COUNT2, 8'h14, "gated");
    rc(`GEC_OFF_COUNT2, 8'h14, "held");
    rc(`GEC_OFF_IRQSTAT, 8'h0B, "status");
    chk("irq", 8'h01, {7'h00, irq_r});
    wr(`GEC_OFF_IRQEN, 8'h00);
    wr(`GEC_OFF_IRQCLR, 8'h0F);
    // PWM: toggles at the high match and at the period match
    wr(`GEC_OFF_CTRL, 8'h00);
    wr(`GEC_OFF_MATCH2H, 8'h02);
    wr(`GEC_OFF_MATCH2, 8'h04);
    wr(`GEC_OFF_MODE2, 8'h3D);
    wait_chg(1'b1, n);
    wait_chg(1'b1, n);
    wait_chg(1'b1, a);
    chk("pwm period", 8'h05, n[7:0] + a[7:0]);
    print_verdict;
  end
endmodule
